/* verilog/csp_pkg.sv */
// constants for the clocked serial port: register offsets, field positions,
// reset values and divider counts; needs nothing from its surroundings
`default_nettype none
package csp_pkg;
    // register byte offsets on the avalon slave
    localparam logic [3:0] OFF_CTRL   = 4'h0;
    localparam logic [3:0] OFF_TXBUF  = 4'h4;
    localparam logic [3:0] OFF_RXBUF  = 4'h8;
    localparam logic [3:0] OFF_STATUS = 4'hC;

    // control register fields
    localparam int CTRL_W      = 12;
    localparam int P_TX_EN     = 0;
    localparam int P_RX_EN     = 1;
    localparam int P_CLK_EXT   = 2;
    localparam int P_CPOL      = 3;
    localparam int P_MSB_FIRST = 4;
    localparam int P_TX_IRQ_TC = 5;
    localparam int P_CONT_RX   = 6;
    localparam int P_DIV_LO    = 8;
    localparam int P_ROUTE_LO  = 10;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;

    // status register fields
    localparam int P_TXBUF_EMPTY = 0;
    localparam int P_TXREG_EMPTY = 1;
    localparam int P_RX_DONE     = 2;
    localparam int P_OVERRUN     = 3;
    localparam int P_TX_IRQ      = 4;
    localparam int P_RX_IRQ      = 5;

    // shift clock source selection
    localparam logic [1:0] DIV_SEL_1   = 2'h0;
    localparam logic [1:0] DIV_SEL_8   = 2'h1;
    localparam logic [1:0] DIV_SEL_32  = 2'h2;
    localparam logic [1:0] DIV_SEL_SUB = 2'h3;
    localparam logic [5:0] DIV_CNT_1   = 6'h01;
    localparam logic [5:0] DIV_CNT_8   = 6'h08;
    localparam logic [5:0] DIV_CNT_32  = 6'h20;

    // route select code that moves the shift clock to the alternate pin
    localparam logic [1:0] ROUTE_ALT = 2'h3;

    localparam logic [2:0] LAST_BIT = 3'h7;
endpackage : csp_pkg
`default_nettype wire

/* verilog/csp_sync.sv */
// two-flop synchroniser for pin inputs
// assumes inputs are asynchronous to clock; only stage two is read outside
`timescale 1ns/1ps
`default_nettype none
module csp_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : csp_sync
`default_nettype wire

/* verilog/csp_clkgen.sv */
// half-period tick source for the internal shift clock
// assumes sub_clk_sync is already synchronised to clock
`timescale 1ns/1ps
`default_nettype none
module csp_clkgen (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [1:0] div_sel,
    input  wire logic       sub_clk_sync,
    output logic            tick
);
    logic [5:0] cnt_q;
    logic       sub_last_q;
    logic [5:0] limit;
    logic       div_wrap;
    logic       sub_rise;

    function automatic logic [5:0] div_limit(input logic [1:0] sel);
        case (sel)
            csp_pkg::DIV_SEL_8:  div_limit = csp_pkg::DIV_CNT_8;
            csp_pkg::DIV_SEL_32: div_limit = csp_pkg::DIV_CNT_32;
            default:             div_limit = csp_pkg::DIV_CNT_1;
        endcase
    endfunction : div_limit

    assign limit    = div_limit(div_sel);
    assign div_wrap = (cnt_q >= limit - 6'h01);
    assign sub_rise = sub_clk_sync && !sub_last_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_q      <= 6'h00;
            sub_last_q <= 1'b0;
            tick       <= 1'b0;
        end else begin
            sub_last_q <= sub_clk_sync;
            cnt_q      <= div_wrap ? 6'h00 : cnt_q + 6'h01;
            tick       <= (div_sel == csp_pkg::DIV_SEL_SUB) ? sub_rise : div_wrap;
        end
    end
endmodule : csp_clkgen
`default_nettype wire

/* verilog/csp_port.sv */
// clocked serial port: byte-wide synchronous serial transmitter and receiver
// assumes an avalon-mm master on clock; pins come from outside and are synchronised
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module csp_port (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        shift_clock_pin_i,
    output logic             shift_clock_pin_o,
    output logic             shift_clock_pin_oe,
    output logic             alternate_clock_out_pin_o,
    output logic             alternate_clock_out_pin_oe,
    input  wire logic        serial_data_in_pin,
    output logic             serial_data_out_pin_o,
    output logic             serial_data_out_pin_oe,
    input  wire logic        sub_clock_source
);
    // register state
    logic [csp_pkg::CTRL_W-1:0] ctrl_q;
    logic [7:0]  txbuf_q;
    logic        txbuf_full_q;
    logic [7:0]  rxbuf_q;
    logic        txreg_empty_q;
    logic        rx_done_q;
    logic        overrun_q;
    logic        tx_irq_q;
    logic        rx_irq_q;
    logic        rx_armed_q;
    logic        rx_act_q;
    logic        wait_q;
    logic [31:0] rdata_q;

    // shift engine state
    logic        busy_q;
    logic [2:0]  bit_cnt_q;
    logic [7:0]  tx_sh_q;
    logic [7:0]  rx_sh_q;
    logic        sclk_q;
    logic        dout_q;
    logic        clk_last_q;
    logic        pri_oe_q;
    logic        alt_oe_q;
    logic        dout_oe_q;

    // synchronised pins: {shift clock, data in, sub clock}
    logic [2:0]  pins_s;
    logic        tick;

    csp_sync #(.WIDTH(3)) u_sync (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in ({shift_clock_pin_i, serial_data_in_pin, sub_clock_source}),
        .sync_out (pins_s)
    );

    csp_clkgen u_clkgen (
        .clock        (clock),
        .rst_n        (rst_n),
        .div_sel      (ctrl_q[csp_pkg::P_DIV_LO +: 2]),
        .sub_clk_sync (pins_s[0]),
        .tick         (tick)
    );

    function automatic logic first_bit(input logic [7:0] b, input logic msb);
        first_bit = msb ? b[7] : b[0];
    endfunction : first_bit

    // control fields
    wire tx_en   = ctrl_q[csp_pkg::P_TX_EN];
    wire rx_en   = ctrl_q[csp_pkg::P_RX_EN];
    wire clk_ext = ctrl_q[csp_pkg::P_CLK_EXT];
    wire cpol    = ctrl_q[csp_pkg::P_CPOL];
    wire msb     = ctrl_q[csp_pkg::P_MSB_FIRST];
    wire irq_tc  = ctrl_q[csp_pkg::P_TX_IRQ_TC];
    wire cont_rx = ctrl_q[csp_pkg::P_CONT_RX];
    wire idle_lvl = !cpol;
    // route changes are not retimed; software keeps them to idle time
    wire alt_sel = (ctrl_q[csp_pkg::P_ROUTE_LO +: 2] == csp_pkg::ROUTE_ALT) && !clk_ext;

    // bus decode: the access completes on the edge where waitrequest is low
    wire acc       = (avs_read || avs_write) && !wait_q;
    wire wr        = avs_write && acc;
    wire rd        = avs_read && acc;
    wire wr_ctrl   = wr && (avs_address == csp_pkg::OFF_CTRL);
    wire wr_txbuf  = wr && (avs_address == csp_pkg::OFF_TXBUF);
    wire wr_status = wr && (avs_address == csp_pkg::OFF_STATUS);
    wire rd_rxbuf  = rd && (avs_address == csp_pkg::OFF_RXBUF);

    wire [31:0] status_word = {26'h0, rx_irq_q, tx_irq_q, overrun_q, rx_done_q, txreg_empty_q, !txbuf_full_q};
    wire [31:0] rd_mux =
        (avs_address == csp_pkg::OFF_CTRL)   ? {20'h00000, ctrl_q} :
        (avs_address == csp_pkg::OFF_TXBUF)  ? {24'h000000, txbuf_q} :
        (avs_address == csp_pkg::OFF_RXBUF)  ? {24'h000000, rxbuf_q} :
        (avs_address == csp_pkg::OFF_STATUS) ? status_word : 32'h00000000;

    // start needs the transmitter even for receive-only use
    wire start_ok = tx_en && (txbuf_full_q || (cont_rx && rx_en && rx_armed_q));

    // internal clock: each tick toggles the shift clock while a byte runs
    wire int_drive  = !clk_ext && tick && (busy_q ? (sclk_q == idle_lvl) : start_ok);
    wire int_sample = !clk_ext && tick && busy_q && (sclk_q != idle_lvl);

    // external clock: edges found on the synchronised pin; a partner that does
    // not idle at the polarity level during set-up gives a spurious first edge
    wire ext_rise   = pins_s[2] && !clk_last_q;
    wire ext_fall   = !pins_s[2] && clk_last_q;
    wire ext_drive  = clk_ext && (cpol ? ext_rise : ext_fall) && (busy_q || start_ok);
    wire ext_sample = clk_ext && (cpol ? ext_fall : ext_rise) && busy_q;

    wire drive_ev  = int_drive || ext_drive;
    wire sample_ev = int_sample || ext_sample;
    wire load      = drive_ev && !busy_q;
    wire done      = sample_ev && (bit_cnt_q == csp_pkg::LAST_BIT);
    wire done_rx   = done && rx_act_q;
    wire din       = pins_s[1];

    wire [7:0] rx_next = msb ? {rx_sh_q[6:0], din} : {din, rx_sh_q[7:1]};
    wire [7:0] tx_next = msb ? {tx_sh_q[6:0], 1'b0} : {1'b0, tx_sh_q[7:1]};

    // avalon slave: one wait cycle, then read data and waitrequest low together
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h00000000;
        end else begin
            wait_q  <= !((avs_read || avs_write) && wait_q);
            rdata_q <= ((avs_read || avs_write) && wait_q) ? rd_mux : rdata_q;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_q  <= csp_pkg::CTRL_RESET;
            txbuf_q <= 8'h00;
        end else begin
            ctrl_q  <= wr_ctrl ? avs_writedata[csp_pkg::CTRL_W-1:0] : ctrl_q;
            txbuf_q <= wr_txbuf ? avs_writedata[7:0] : txbuf_q;
        end
    end

    // buffer and flag state; hardware set wins over a software clear
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            txbuf_full_q  <= 1'b0;
            txreg_empty_q <= 1'b1;
            tx_irq_q      <= 1'b0;
            rx_done_q     <= 1'b0;
            rx_irq_q      <= 1'b0;
            overrun_q     <= 1'b0;
            rx_armed_q    <= 1'b0;
            rx_act_q      <= 1'b0;
            rxbuf_q       <= 8'h00;
        end else begin
            txbuf_full_q  <= wr_txbuf || (txbuf_full_q && !load);
            txreg_empty_q <= done || (txreg_empty_q && !load);
            if ((load && !irq_tc) || (done && irq_tc)) begin
                tx_irq_q <= 1'b1;
            end else begin
                tx_irq_q <= tx_irq_q && !(wr_status && avs_writedata[csp_pkg::P_TX_IRQ]);
            end
            rx_done_q <= done_rx || (rx_done_q && !rd_rxbuf);
            if (done_rx && !rx_done_q) begin
                rx_irq_q <= 1'b1;
            end else begin
                rx_irq_q <= rx_irq_q && !(wr_status && avs_writedata[csp_pkg::P_RX_IRQ]);
            end
            // overrun clears only when reception is disabled
            overrun_q <= (done_rx && rx_done_q) || (overrun_q && rx_en);
            rxbuf_q   <= done_rx ? rx_next : rxbuf_q;
            if ((wr_txbuf && rx_en && tx_en && !cont_rx) || (rd_rxbuf && rx_en && cont_rx)) begin
                rx_armed_q <= 1'b1;
            end else begin
                rx_armed_q <= rx_armed_q && !load && rx_en;
            end
            rx_act_q <= load ? (rx_en && rx_armed_q) : (rx_act_q && !done);
        end
    end

    // shift engine
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            busy_q     <= 1'b0;
            bit_cnt_q  <= 3'h0;
            tx_sh_q    <= 8'h00;
            rx_sh_q    <= 8'h00;
            dout_q     <= 1'b1;
            clk_last_q <= 1'b0;
        end else begin
            clk_last_q <= pins_s[2];
            busy_q     <= load || (busy_q && !done);
            bit_cnt_q  <= done ? 3'h0 : (sample_ev ? bit_cnt_q + 3'h1 : bit_cnt_q);
            if (load) begin
                tx_sh_q <= txbuf_q;
                dout_q  <= first_bit(txbuf_q, msb);
            end else if (drive_ev) begin
                tx_sh_q <= tx_next;
                dout_q  <= first_bit(tx_next, msb);
            end
            rx_sh_q <= (sample_ev && rx_act_q) ? rx_next : rx_sh_q;
        end
    end

    // shift clock and pin enables; clock rests at idle level between bytes
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sclk_q    <= 1'b1;
            pri_oe_q  <= 1'b0;
            alt_oe_q  <= 1'b0;
            dout_oe_q <= 1'b0;
        end else begin
            if (int_drive || int_sample) begin
                sclk_q <= !sclk_q;
            end else if (!busy_q) begin
                sclk_q <= idle_lvl;
            end
            pri_oe_q  <= !clk_ext && !alt_sel;
            alt_oe_q  <= alt_sel;
            dout_oe_q <= tx_en;
        end
    end

    assign avs_readdata               = rdata_q;
    assign avs_waitrequest            = wait_q;
    assign shift_clock_pin_o          = sclk_q;
    assign shift_clock_pin_oe         = pri_oe_q;
    assign alternate_clock_out_pin_o  = sclk_q;
    assign alternate_clock_out_pin_oe = alt_oe_q;
    assign serial_data_out_pin_o      = dout_q;
    assign serial_data_out_pin_oe     = dout_oe_q;
endmodule : csp_port
`default_nettype wire

/* test/csp_port_sva.sv */
// assertions for csp_port: bus handshake, clock pin routing, data edges
// bound into csp_port; mirrors the control word from completed bus writes
`timescale 1ns/1ps
`default_nettype none
module csp_port_sva (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        shift_clock_pin_o,
    input wire logic        shift_clock_pin_oe,
    input wire logic        alternate_clock_out_pin_oe,
    input wire logic        serial_data_out_pin_o,
    input wire logic        serial_data_out_pin_oe
);
    logic [11:0] ctrl_q;
    wire         rd_ok   = avs_read && !avs_waitrequest;
    wire         wr_ctrl = avs_write && !avs_waitrequest && avs_address == csp_pkg::OFF_CTRL;
    wire         alt_on  = ctrl_q[11:10] == csp_pkg::ROUTE_ALT && !ctrl_q[csp_pkg::P_CLK_EXT];
    always_ff @(posedge clock) begin
        if (!rst_n) ctrl_q <= csp_pkg::CTRL_RESET;
        else if (wr_ctrl) ctrl_q <= avs_writedata[11:0];
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered after one wait cycle");
    chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_rd_unmapped: assert property (rd_ok && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
        else $error("unmapped read returned data");
    chk_rd_byte: assert property (rd_ok && avs_address inside {4'h4, 4'h8} |-> avs_readdata[31:8] == 24'h0)
        else $error("byte register read has upper bits set");
    chk_dout_en: assert property ($rose(ctrl_q[0]) |-> ##[0:2] serial_data_out_pin_oe)
        else $error("data out not driven after transmit enable");
    chk_dout_off: assert property ($fell(ctrl_q[0]) |-> ##[0:2] !serial_data_out_pin_oe)
        else $error("data out still driven after transmit disable");
    chk_alt_route: assert property (alt_on [*3] |-> alternate_clock_out_pin_oe && !shift_clock_pin_oe)
        else $error("shift clock not moved to alternate pin");
    chk_ext_quiet: assert property (ctrl_q[2] [*3] |-> !alternate_clock_out_pin_oe && !shift_clock_pin_oe)
        else $error("clock pin driven with external clock");
    chk_dout_edge: assert property ($changed(serial_data_out_pin_o) && shift_clock_pin_oe |->
        $changed(shift_clock_pin_o) && shift_clock_pin_o == ctrl_q[csp_pkg::P_CPOL])
        else $error("data out changed off the shift-out edge");
    chk_pins_excl: assert property (!(shift_clock_pin_oe && alternate_clock_out_pin_oe))
        else $error("both clock pins driven");
endmodule : csp_port_sva
bind csp_port csp_port_sva u_sva (
    .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .shift_clock_pin_o(shift_clock_pin_o),
    .shift_clock_pin_oe(shift_clock_pin_oe), .alternate_clock_out_pin_oe(alternate_clock_out_pin_oe),
    .serial_data_out_pin_o(serial_data_out_pin_o), .serial_data_out_pin_oe(serial_data_out_pin_oe)
);
`default_nettype wire

/* test/csp_peer.sv */
// serial peer: shifts one byte out and one in on the shared shift clock
// assumes the bench resolves the clock wire and pulses clr before each frame
`timescale 1ns/1ps
`default_nettype none
module csp_peer (
    input  wire logic       sclk,
    input  wire logic       dout,
    input  wire logic       cpol,
    input  wire logic       msb,
    input  wire logic       clr,
    input  wire logic       go_ext,
    input  wire logic [7:0] send,
    output logic            ext_clk,
    output logic            din,
    output logic [7:0]      got
);
    int n;
    initial begin
        ext_clk = 1'b1;
        din = 1'b1;
        got = 8'h00;
        n = 0;
    end
    always @(posedge clr) begin
        n = 0;
        got = 8'h00;
    end
    always @(sclk) begin
        if (!clr && n < 8 && sclk === cpol) begin
            din = msb ? send[7-n] : send[n];
        end else if (!clr && n < 8 && sclk === !cpol) begin
            got = msb ? {got[6:0], dout} : {dout, got[7:1]};
            n = n + 1;
            // line is flipped once at the last bit and then held, so a stale bit cannot pass
            if (n == 8) din = !din;
        end
    end
    always @(posedge go_ext) begin
        repeat (8) begin
            #62.5 ext_clk = cpol;
            #62.5 ext_clk = !cpol;
        end
    end
endmodule : csp_peer
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for csp_port: register tasks, frames against a serial peer
// assumes the checker binds itself; sub clock and link clock are made here
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clock, rst_n, avs_read, avs_write, sub_clk, clr, go, p_cpol, p_msb;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, q;
    logic [7:0]  send;
    wire  [31:0] rdata;
    wire         wait_w, so, soe, ao, aoe, dout, doe, ext_clk, din;
    wire  [7:0]  got;
    wire         sclk_w = soe ? so : (aoe ? ao : ext_clk);
    wire         dout_w = doe ? dout : !dout;
    int          error_cnt, checks, i;
    // last frame asks for the alternate route with the pin clock, which must leave both clock pins quiet
    localparam logic [11:0] CFG [7] = '{12'h103, 12'h11B, 12'h233, 12'h30B, 12'h003, 12'hC03, 12'hC07};
    localparam logic [7:0]  SND [7] = '{8'hA5, 8'h81, 8'h01, 8'hC6, 8'h00, 8'h00, 8'h5A};
    localparam logic [7:0]  BYT [7] = '{8'h3C, 8'h7E, 8'hF0, 8'h1D, 8'h96, 8'h5B, 8'hC3};
    csp_port u_dut (
        .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(rdata),
        .avs_waitrequest(wait_w), .shift_clock_pin_i(sclk_w), .shift_clock_pin_o(so),
        .shift_clock_pin_oe(soe), .alternate_clock_out_pin_o(ao), .alternate_clock_out_pin_oe(aoe),
        .serial_data_in_pin(din), .serial_data_out_pin_o(dout), .serial_data_out_pin_oe(doe),
        .sub_clock_source(sub_clk)
    );
    csp_peer u_peer (
        .sclk(sclk_w), .dout(dout_w), .cpol(p_cpol), .msb(p_msb), .clr(clr), .go_ext(go),
        .send(send), .ext_clk(ext_clk), .din(din), .got(got)
    );
    initial begin
        clock = 1'b0;
        forever #5 clock = !clock;
    end
    initial begin
        sub_clk = 1'b0;
        forever #80 sub_clk = !sub_clk;
    end
    task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clock);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do @(posedge clock); while (wait_w !== 1'b0);
        r = rdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : acc
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] r;
        acc(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] r);
        acc(1'b0, a, 32'h0, r);
    endtask : rd
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wait_st(input int b);
        logic [31:0] s;
        int          k;
        s = 32'h0;
        // bounded poll: a frame on the sub clock takes a few hundred cycles
        for (k = 0; k < 3000 && s[b] !== 1'b1; k++) rd(csp_pkg::OFF_STATUS, s);
        chk("status bit", {31'h0, s[b]}, 32'h1);
    endtask : wait_st
    task automatic pulse_clr;
        clr <= 1'b1;
        // held over two edges: the clock pin moves to its new idle level one edge after a control write
        repeat (2) @(posedge clock);
        clr <= 1'b0;
    endtask : pulse_clr
    task automatic run_case(input logic [11:0] c, input logic [7:0] s, input logic [7:0] b);
        logic [31:0] r;
        p_cpol <= c[3];
        p_msb  <= c[4];
        send   <= s;
        go     <= 1'b0;
        if (c[2]) wr(csp_pkg::OFF_CTRL, {20'h0, c & 12'hFFE});
        wr(csp_pkg::OFF_CTRL, {20'h0, c});
        pulse_clr;
        wr(csp_pkg::OFF_TXBUF, {24'h0, b});
        go <= c[2];
        wait_st(csp_pkg::P_TXBUF_EMPTY);
        rd(csp_pkg::OFF_STATUS, r);
        chk("tx irq at buffer move", {31'h0, r[4]}, {31'h0, !c[5]});
        wait_st(csp_pkg::P_RX_DONE);
        rd(csp_pkg::OFF_STATUS, r);
        chk("status after byte", {26'h0, r[5:0]}, 32'h37);
        rd(csp_pkg::OFF_RXBUF, r);
        // at divide by one the sampled pin lags two cycles, a whole period, so data is not judged
        if (c[9:8] != 2'h0 || c[2]) chk("rx byte", r, {24'h0, s});
        chk("peer byte", {24'h0, got}, {24'h0, b});
        rd(csp_pkg::OFF_STATUS, r);
        chk("rx done cleared", {31'h0, r[2]}, 32'h0);
        wr(csp_pkg::OFF_STATUS, 32'h30);
    endtask : run_case
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    initial begin
        #500000;
        error_cnt++;
        print_verdict;
    end
    initial begin
        {avs_read, avs_write, rst_n, clr, go, p_cpol, p_msb} = 7'h00;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        send = 8'h00;
        error_cnt = 0;
        checks = 0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        rd(csp_pkg::OFF_CTRL, q);
        chk("ctrl reset", q, 32'h0);
        rd(csp_pkg::OFF_STATUS, q);
        chk("status reset", q, 32'h3);
        wr(4'h2, 32'hFFF);
        rd(4'h2, q);
        chk("unmapped read", q, 32'h0);
        rd(csp_pkg::OFF_CTRL, q);
        chk("unmapped write ignored", q, 32'h0);
        $display("test reset done");
        for (i = 0; i < 7; i++) begin
            run_case(CFG[i], SND[i], BYT[i]);
            $display("test frame %0d done", i);
        end
        wr(csp_pkg::OFF_CTRL, 32'h103);
        pulse_clr;
        wr(csp_pkg::OFF_TXBUF, 32'h11);
        wait_st(csp_pkg::P_RX_DONE);
        wr(csp_pkg::OFF_STATUS, 32'h30);
        pulse_clr;
        send <= 8'h96;
        wr(csp_pkg::OFF_TXBUF, 32'h22);
        wait_st(csp_pkg::P_OVERRUN);
        rd(csp_pkg::OFF_STATUS, q);
        chk("rx irq on overrun", {31'h0, q[5]}, 32'h0);
        rd(csp_pkg::OFF_RXBUF, q);
        chk("overwritten rx byte", q, 32'h96);
        wr(csp_pkg::OFF_CTRL, 32'h0);
        rd(csp_pkg::OFF_STATUS, q);
        chk("overrun cleared", {31'h0, q[3]}, 32'h0);
        wr(csp_pkg::OFF_CTRL, 32'h103);
        repeat (300) @(posedge clock);
        rd(csp_pkg::OFF_STATUS, q);
        chk("no rx without dummy", {31'h0, q[2]}, 32'h0);
        $display("test overrun done");
        wr(csp_pkg::OFF_CTRL, 32'h143);
        pulse_clr;
        send <= 8'h3C;
        rd(csp_pkg::OFF_RXBUF, q);
        wait_st(csp_pkg::P_RX_DONE);
        rd(csp_pkg::OFF_RXBUF, q);
        chk("successive rx byte", q, 32'h3C);
        $display("test successive done");
        print_verdict;
    end
endmodule : tb_top
`default_nettype wire
